// >>> core/eta_target_access.sv
// configurable debug target-access engine of the emulator
// Functional notes
// - default reset: run from high vector
// - halt-high reset: stop at high vector
// - run-low reset: run from low vector
// - halt-low reset: stop at low vector
// - scan-only reset; others also reset scan
// - stall reads by configured microseconds
// - stall writes by separate microsecond count
// - generate parity only when enabled
// - parity covers data lines, not address
// - narrow mode caps accesses at 4 bytes
// - retry handling only with a cache on
// - caches off: reads return physical memory
// - coherent read: cache hit wins
// - physical-only read bypasses both caches
// - decode valid encoded instruction cache entries
// - download writes memory, invalidates caches
// - unspecified write space means instruction space
// - data cache off: data write physical
// - copy-back write: hit updates cache dirty
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
module eta_target_access (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [3:0]       cfg_addr,
  input  wire logic [31:0]      cfg_wdata,
  input  wire logic             cfg_wr,
  input  wire logic             cfg_rd,
  output logic      [31:0]      cfg_rdata,
  input  wire logic             req_valid,
  output logic                  req_ready,
  input  wire eta_pkg::eta_req_s req,
  output logic                  done,
  output logic      [63:0]      rdata,
  input  wire logic             instr_cache_on_bit,
  input  wire logic             data_cache_on_bit,
  input  wire logic             icache_hit,
  input  wire logic             dcache_hit,
  input  wire logic             icache_encoded,
  input  wire logic             insn_valid,
  input  wire logic [63:0]      icache_raw,
  input  wire logic [63:0]      icache_dec,
  input  wire logic [63:0]      dcache_data,
  input  wire logic [63:0]      phys_data,
  input  wire logic             scan_ack,
  input  wire logic             link_clk,
  output logic                  scan_go,
  output eta_pkg::eta_plan_s    plan,
  output logic [31:0]           addr_out,
  output logic                  core_rst,
  output logic                  scan_rst,
  output logic                  halt_req,
  output logic [31:0]           start_vector
);

  // ------------------------------------------------------------------
  // config command registers
  // ------------------------------------------------------------------
  localparam logic [3:0] A_RESET   = 4'h0;
  localparam logic [3:0] A_RDDEL   = 4'h1;
  localparam logic [3:0] A_WRDEL   = 4'h2;
  localparam logic [3:0] A_MODE    = 4'h3;
  localparam logic [3:0] A_STATUS  = 4'h4;
  localparam logic [3:0] A_RST_CMD = 4'h5;

  eta_pkg::eta_cfg_s cfg_q;
  logic              rst_go;

  // values above the largest legal delay saturate
  function automatic logic [19:0] clip_us(input logic [31:0] v);
    clip_us = (v > 32'(eta_pkg::ETA_DELAY_MAX_US)) ? 20'(eta_pkg::ETA_DELAY_MAX_US) : v[19:0];
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q.rst_mode               <= eta_pkg::ETA_RST_RUN_HIGH;
      cfg_q.rd_delay_us            <= eta_pkg::ETA_RD_DELAY_RST;
      cfg_q.wr_delay_us            <= eta_pkg::ETA_WR_DELAY_RST;
      cfg_q.parity_on              <= 1'b0;
      cfg_q.narrow_bus_select      <= 1'b0;
      cfg_q.retry_on               <= 1'b0;
      cfg_q.coherent_access_policy <= 1'b1;
      cfg_q.dwr_mode               <= eta_pkg::ETA_DW_COPYBACK;
    end else if (cfg_wr) begin
      case (cfg_addr)
        A_RESET: begin
          if (cfg_wdata[2:0] <= 3'h4) begin
            cfg_q.rst_mode <= eta_pkg::eta_rst_mode_e'(cfg_wdata[2:0]);
          end
        end
        A_RDDEL: cfg_q.rd_delay_us <= clip_us(cfg_wdata);
        A_WRDEL: cfg_q.wr_delay_us <= clip_us(cfg_wdata);
        A_MODE: begin
          cfg_q.parity_on              <= cfg_wdata[0];
          cfg_q.narrow_bus_select      <= cfg_wdata[1];
          cfg_q.retry_on               <= cfg_wdata[2];
          cfg_q.coherent_access_policy <= cfg_wdata[3];
          if (cfg_wdata[5:4] != 2'h3) begin
            cfg_q.dwr_mode <= eta_pkg::eta_dwr_mode_e'(cfg_wdata[5:4]);
          end
        end
        default: ;
      endcase
    end
  end

  assign rst_go = cfg_wr && (cfg_addr == A_RST_CMD);

  // ------------------------------------------------------------------
  // link clock sampling
  // ------------------------------------------------------------------
  logic lclk_m_q;
  logic lclk_s_q;
  logic lclk_p_q;
  logic lclk_rise;
  logic ack_m_q;
  logic ack_s_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lclk_m_q <= 1'b0;
      lclk_s_q <= 1'b0;
      lclk_p_q <= 1'b0;
      ack_m_q  <= 1'b0;
      ack_s_q  <= 1'b0;
    end else begin
      lclk_m_q <= link_clk;
      lclk_s_q <= lclk_m_q;
      lclk_p_q <= lclk_s_q;
      ack_m_q  <= scan_ack;
      ack_s_q  <= ack_m_q;
    end
  end

  // the target side only moves on its own clock edges
  assign lclk_rise = lclk_s_q && !lclk_p_q;

  // ------------------------------------------------------------------
  // access planning
  // ------------------------------------------------------------------
  logic              any_cache;
  logic              is_data;
  eta_pkg::eta_plan_s plan_d;

  assign any_cache = instr_cache_on_bit || data_cache_on_bit;
  assign is_data   = req.space_given && req.data_space;

  function automatic logic [7:0] lane_parity(input logic [63:0] d);
    for (int i = 0; i < 8; i++) begin
      lane_parity[i] = ~^d[8*i +: 8];
    end
  endfunction

  always_comb begin
    plan_d          = '0;
    plan_d.retry_hs = cfg_q.retry_on && any_cache;
    plan_d.size     = (cfg_q.narrow_bus_select && req.size > eta_pkg::ETA_SIZE_4B) ?
                      eta_pkg::ETA_SIZE_4B : req.size;
    if (req.write) begin
      // data lines only; address lines never get parity
      plan_d.par = cfg_q.parity_on ? lane_parity(req.wdata) : 8'h00;
      if (req.download) begin
        plan_d.to_phys    = 1'b1;
        plan_d.invalidate = 1'b1;
      end else if (is_data) begin
        if (!data_cache_on_bit) begin
          plan_d.to_phys = 1'b1;
        end else begin
          case (cfg_q.dwr_mode)
            eta_pkg::ETA_DW_COPYBACK: begin
              plan_d.to_dcache  = dcache_hit;
              plan_d.mark_dirty = dcache_hit;
              plan_d.to_phys    = !dcache_hit;
            end
            eta_pkg::ETA_DW_THRU: begin
              plan_d.to_dcache = dcache_hit;
              plan_d.to_phys   = 1'b1;
            end
            default: plan_d.to_phys = 1'b1;
          endcase
        end
      end else begin
        // instruction space: update whichever cache holds the line
        plan_d.to_phys   = 1'b1;
        plan_d.to_icache = instr_cache_on_bit && icache_hit;
        plan_d.to_dcache = data_cache_on_bit && dcache_hit;
      end
    end else begin
      plan_d.par = cfg_q.parity_on ? 8'hff : 8'h00;
      if (!any_cache || !cfg_q.coherent_access_policy) begin
        plan_d.to_phys = 1'b1;
      end else if (instr_cache_on_bit && icache_hit) begin
        plan_d.to_icache = 1'b1;
      end else if (data_cache_on_bit && dcache_hit) begin
        plan_d.to_dcache = 1'b1;
      end else begin
        plan_d.to_phys = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_SCAN,
    S_WAIT_ACK,
    S_STALL,
    S_RST_PULSE,
    S_RST_HOLD
  } eta_state_e;

  eta_state_e  state_q;
  logic        stall_start;
  logic        stall_busy;
  logic        rd_load;
  logic        is_wr_q;
  logic [5:0]  rst_cnt_q;

  assign req_ready   = (state_q == S_IDLE) && !rst_go;
  assign stall_start = (state_q == S_WAIT_ACK) && ack_s_q;
  assign rd_load     = stall_start && !is_wr_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q   <= S_IDLE;
      plan      <= '0;
      addr_out  <= 32'h0000_0000;
      is_wr_q   <= 1'b0;
      scan_go   <= 1'b0;
      done      <= 1'b0;
      rst_cnt_q <= 6'h00;
    end else begin
      done <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (rst_go) begin
            rst_cnt_q <= 6'(eta_pkg::ETA_RST_PULSE_CYC);
            state_q   <= S_RST_PULSE;
          end else if (req_valid) begin
            plan     <= plan_d;
            addr_out <= req.addr;
            is_wr_q  <= req.write;
            state_q  <= S_SCAN;
          end
        end
        S_SCAN: begin
          if (lclk_rise) begin
            scan_go <= 1'b1;
            state_q <= S_WAIT_ACK;
          end
        end
        S_WAIT_ACK: begin
          if (ack_s_q) begin
            scan_go <= 1'b0;
            state_q <= S_STALL;
          end
        end
        S_STALL: begin
          // the timer needs one cycle to load before busy is valid
          if (!stall_busy && !ack_s_q) begin
            done    <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_RST_PULSE: begin
          if (rst_cnt_q == 6'h00) begin
            state_q <= S_RST_HOLD;
          end else begin
            rst_cnt_q <= rst_cnt_q - 6'h01;
          end
        end
        S_RST_HOLD: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  eta_delay u_delay (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .start    (stall_start),
    .delay_us (is_wr_q ? cfg_q.wr_delay_us : cfg_q.rd_delay_us),
    .busy     (stall_busy)
  );

  eta_rdsel u_rdsel (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .load           (rd_load),
    .from_icache    (plan.to_icache),
    .from_dcache    (plan.to_dcache),
    .icache_encoded (icache_encoded),
    .insn_valid     (insn_valid),
    .icache_raw     (icache_raw),
    .icache_dec     (icache_dec),
    .dcache_data    (dcache_data),
    .phys_data      (phys_data),
    .narrow         (cfg_q.narrow_bus_select),
    .rdata          (rdata)
  );

  // ------------------------------------------------------------------
  // target reset control
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_rst     <= 1'b0;
      scan_rst     <= 1'b0;
      halt_req     <= 1'b0;
      start_vector <= eta_pkg::ETA_HIGH_VECTOR;
    end else if (state_q == S_RST_PULSE) begin
      scan_rst <= 1'b1;
      core_rst <= (cfg_q.rst_mode != eta_pkg::ETA_RST_SCAN_ONLY);
      case (cfg_q.rst_mode)
        eta_pkg::ETA_RST_RUN_HIGH: begin
          start_vector <= eta_pkg::ETA_HIGH_VECTOR;
          halt_req     <= 1'b0;
        end
        eta_pkg::ETA_RST_HALT_HIGH: begin
          start_vector <= eta_pkg::ETA_HIGH_VECTOR;
          halt_req     <= 1'b1;
        end
        eta_pkg::ETA_RST_RUN_LOW: begin
          start_vector <= eta_pkg::ETA_LOW_VECTOR;
          halt_req     <= 1'b0;
        end
        eta_pkg::ETA_RST_HALT_LOW: begin
          start_vector <= eta_pkg::ETA_LOW_VECTOR;
          halt_req     <= 1'b1;
        end
        default: ;
      endcase
    end else begin
      core_rst <= 1'b0;
      scan_rst <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // config read-back
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || !cfg_rd) begin
      cfg_rdata <= 32'h0000_0000;
    end else begin
      case (cfg_addr)
        A_RESET:  cfg_rdata <= {29'h0, cfg_q.rst_mode};
        A_RDDEL:  cfg_rdata <= {12'h000, cfg_q.rd_delay_us};
        A_WRDEL:  cfg_rdata <= {12'h000, cfg_q.wr_delay_us};
        A_MODE:   cfg_rdata <= {26'h0, cfg_q.dwr_mode, cfg_q.coherent_access_policy,
                                cfg_q.retry_on, cfg_q.narrow_bus_select, cfg_q.parity_on};
        A_STATUS: cfg_rdata <= {26'h0, halt_req, core_rst, scan_rst, state_q};
        default:  cfg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> include/eta_pkg.sv
// shared types and constants for the emulator target-access block
package eta_pkg;

  // reset actions
  typedef enum logic [2:0] {
    ETA_RST_RUN_HIGH,
    ETA_RST_HALT_HIGH,
    ETA_RST_RUN_LOW,
    ETA_RST_HALT_LOW,
    ETA_RST_SCAN_ONLY
  } eta_rst_mode_e;

  // data-write policies
  typedef enum logic [1:0] {
    ETA_DW_COPYBACK,
    ETA_DW_THRU,
    ETA_DW_BYPASS
  } eta_dwr_mode_e;

  // ------------------------------------------------------------------
  // constants
  // ------------------------------------------------------------------
  localparam logic [31:0] ETA_HIGH_VECTOR   = 32'h0fff_0100;
  localparam logic [31:0] ETA_LOW_VECTOR    = 32'h0000_0100;
  localparam int          ETA_CLK_MHZ       = 25;
  localparam int          ETA_DELAY_MAX_US  = 1000000;
  localparam int          ETA_CLK_PER_US    = ETA_CLK_MHZ;
  localparam int          ETA_RST_PULSE_NS  = 1000;
  localparam int          ETA_RST_PULSE_CYC = (ETA_RST_PULSE_NS * ETA_CLK_MHZ + 999) / 1000;
  localparam logic [2:0]  ETA_SIZE_8B       = 3'h4;
  localparam logic [2:0]  ETA_SIZE_4B       = 3'h3;
  localparam logic [19:0] ETA_RD_DELAY_RST  = 20'h0_0000;
  localparam logic [19:0] ETA_WR_DELAY_RST  = 20'h0_0000;

  // configuration that software sets through the config command
  typedef struct packed {
    eta_rst_mode_e rst_mode;
    logic [19:0]   rd_delay_us;
    logic [19:0]   wr_delay_us;
    logic          parity_on;
    logic          narrow_bus_select;
    logic          retry_on;
    logic          coherent_access_policy;
    eta_dwr_mode_e dwr_mode;
  } eta_cfg_s;

  // one debug memory request
  typedef struct packed {
    logic        write;
    logic        space_given;
    logic        data_space;
    logic        download;
    logic [2:0]  size;
    logic [31:0] addr;
    logic [63:0] wdata;
  } eta_req_s;

  // what the access engine tells the scan sequencer to do
  typedef struct packed {
    logic        to_phys;
    logic        to_icache;
    logic        to_dcache;
    logic        mark_dirty;
    logic        invalidate;
    logic        retry_hs;
    logic [2:0]  size;
    logic [7:0]  par;
  } eta_plan_s;

endpackage

// >>> core/eta_delay.sv
// microsecond stall timer for debug memory accesses
`timescale 1ns/100ps
module eta_delay (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [19:0] delay_us,
  output logic             busy
);

  logic [19:0] us_q;
  logic [4:0]  sub_q;

  // ------------------------------------------------------------------
  // counter
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      us_q  <= 20'h0_0000;
      sub_q <= 5'h00;
    end else if (start) begin
      us_q  <= delay_us;
      sub_q <= 5'(eta_pkg::ETA_CLK_PER_US - 1);
    end else if (us_q != 20'h0_0000) begin
      if (sub_q == 5'h00) begin
        sub_q <= 5'(eta_pkg::ETA_CLK_PER_US - 1);
        us_q  <= us_q - 20'h0_0001;
      end else begin
        sub_q <= sub_q - 5'h01;
      end
    end
  end

  assign busy = (us_q != 20'h0_0000);

endmodule

// >>> core/eta_rdsel.sv
// read-data selection between cache copies and physical memory
`timescale 1ns/100ps
module eta_rdsel (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic        from_icache,
  input  wire logic        from_dcache,
  input  wire logic        icache_encoded,
  input  wire logic        insn_valid,
  input  wire logic [63:0] icache_raw,
  input  wire logic [63:0] icache_dec,
  input  wire logic [63:0] dcache_data,
  input  wire logic [63:0] phys_data,
  input  wire logic        narrow,
  output logic      [63:0] rdata
);

  logic [63:0] pick;

  always_comb begin
    if (from_icache) begin
      // decoded only where the word is a legal instruction
      pick = (icache_encoded && insn_valid) ? icache_dec : icache_raw;
    end else if (from_dcache) begin
      pick = dcache_data;
    end else begin
      pick = phys_data;
    end
    if (narrow) begin
      pick = {32'h0000_0000, pick[31:0]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= 64'h0;
    end else if (load) begin
      rdata <= pick;
    end
  end

endmodule

// >>> verification/eta_target_access_assertions.sv
// concurrent checks on the ports of the target-access block
`timescale 1ns/100ps
module eta_target_access_assertions (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               req_ready,
  input wire logic               done,
  input wire logic               scan_ack,
  input wire logic               scan_go,
  input wire eta_pkg::eta_plan_s plan,
  input wire logic [31:0]        addr_out,
  input wire logic               core_rst,
  input wire logic               scan_rst
);
  // ------------------------------------------------------------------
  // helper: length of the running reset pulse
  // ------------------------------------------------------------------
  logic [7:0] pulse_q;

  always_ff @(posedge sys_clk) begin
    if (rst || !scan_rst) pulse_q <= 8'h00;
    else pulse_q <= pulse_q + 8'h01;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  a_pulse_length: assert property ($fell(scan_rst) |->
                                   pulse_q == eta_pkg::ETA_RST_PULSE_CYC + 1)
    else $error("reset pulse has the wrong length");
  a_core_in_scan: assert property (core_rst |-> scan_rst)
    else $error("core reset without scan reset");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_go_holds: assert property (scan_go && !scan_ack |=> scan_go)
    else $error("scan request dropped before acknowledge");
  a_go_drops: assert property (scan_go && scan_ack |-> ##[1:4] !scan_go)
    else $error("scan request not released after acknowledge");
  a_busy_no_ready: assert property (scan_go |-> !req_ready)
    else $error("ready while an access is in flight");
  a_plan_stable: assert property (scan_go |=> $stable(plan) && $stable(addr_out))
    else $error("plan or address moved during access");
  a_done_quiet: assert property (done |-> !scan_go && !scan_ack)
    else $error("done before the scan handshake closed");
endmodule

// >>> verification/eta_scan_model.sv
// far-side model: target scan port answering debug requests
`timescale 1ns/100ps
module eta_scan_model (
  input  wire logic rst,
  input  wire logic scan_go,
  input  wire logic slow,
  output logic      link_clk,
  output logic      scan_ack
);
  // ------------------------------------------------------------------
  // link clock and acknowledge
  // ------------------------------------------------------------------
  // the link clock runs free so the block can align to it before a frame
  int wait_q;

  initial begin
    link_clk = 1'b0;
    scan_ack = 1'b0;
    wait_q   = 0;
  end

  always #160 link_clk = ~link_clk;

  // ack only after the request stood a while; held until it is dropped
  always @(posedge link_clk) begin
    if (rst || !scan_go) begin
      scan_ack <= 1'b0;
      wait_q   <= 0;
    end else if (wait_q < (slow ? 4 : 1)) begin
      wait_q <= wait_q + 1;
    end else begin
      scan_ack <= 1'b1;
    end
  end
endmodule

// >>> verification/eta_target_access_tb.sv
// self-checking bench for the emulator target-access block
`timescale 1ns/100ps
module eta_target_access_tb;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic               sys_clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [3:0]         cfg_addr = 4'h0;
  logic [31:0]        cfg_wdata = 32'h0, cfg_rdata, addr_out, start_vector, v, ad;
  logic               req_valid = 1'b0, req_ready, done, scan_ack, link_clk, scan_go;
  eta_pkg::eta_req_s  req = '0, rq;
  eta_pkg::eta_plan_s plan, pl;
  logic [63:0]        rdata, icache_raw = '0, icache_dec = '0, dcache_data = '0;
  logic [63:0]        phys_data = '0;
  logic               instr_cache_on_bit = 1'b0, data_cache_on_bit = 1'b0;
  logic               icache_hit = 1'b0, dcache_hit = 1'b0, icache_encoded = 1'b0;
  logic               insn_valid = 1'b0, slow = 1'b0, core_rst, scan_rst, halt_req;
  logic [31:0]        lf = 32'hffc4eb50;
  logic [5:0]         md;
  logic [1:0]         rdd, wrd;
  int                 error_cnt = 0, compares = 0, cyc = 0, n, cnt, cs;

  always #20 sys_clk = ~sys_clk;

  eta_target_access dut (
    .sys_clk, .rst, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata, .req_valid,
    .req_ready, .req, .done, .rdata, .instr_cache_on_bit, .data_cache_on_bit, .icache_hit,
    .dcache_hit, .icache_encoded, .insn_valid, .icache_raw, .icache_dec, .dcache_data,
    .phys_data, .scan_ack, .link_clk, .scan_go, .plan, .addr_out, .core_rst, .scan_rst,
    .halt_req, .start_vector
  );
  eta_scan_model partner (.rst, .scan_go, .slow, .link_clk, .scan_ack);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] odd_par(input logic [63:0] d);
    for (int k = 0; k < 8; k++) odd_par[k] = ~^d[8*k +: 8];
  endfunction
  function automatic logic [63:0] exp_rd();
    logic [63:0] e;
    e = phys_data;
    if (md[3] && icache_hit) e = (icache_encoded && insn_valid) ? icache_dec : icache_raw;
    else if (md[3] && dcache_hit) e = dcache_data;
    if (md[1]) e[63:32] = 32'h0;
    return e;
  endfunction
  // {to_phys, to_dcache, mark_dirty, invalidate}
  function automatic logic [3:0] exp_wr();
    if (rq.download) return 4'b1001;
    if (!data_cache_on_bit || md[5:4] == 2'h2 || !dcache_hit) return 4'b1000;
    return (md[5:4] == 2'h0) ? 4'b0110 : 4'b1100;
  endfunction
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cfg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_wr    <= 1'b1;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic cfg_read(input logic [3:0] a);
    @(posedge sys_clk);
    cfg_addr <= a;
    cfg_rd   <= 1'b1;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
    v = cfg_rdata;
  endtask
  task automatic access();
    @(posedge sys_clk);
    req       <= rq;
    req_valid <= 1'b1;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    pl = plan;
    ad = addr_out;
    n  = 1;
    while (done !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(start_vector, eta_pkg::ETA_HIGH_VECTOR);
    for (int a = 0; a < 5; a++) begin
      cfg_read((a == 4) ? 4'hf : a[3:0]);
      check(v, (a == 3) ? 32'h8 : 32'h0);
    end
    // out-of-range values: delay saturates, bad reset mode is refused
    cfg_write(4'h1, 32'hffff_ffff);
    cfg_read(4'h1);
    check(v, 32'h000f_4240);
    cfg_write(4'h0, 32'h7);
    cfg_read(4'h0);
    check(v, 32'h0);
    for (int m = 0; m < 5; m++) begin
      cfg_write(4'h0, 32'(m));
      cfg_write(4'h5, 32'h0);
      cnt = 0;
      cs  = 0;
      #1;
      repeat (40) begin
        cnt += scan_rst;
        cs  += core_rst;
        @(posedge sys_clk);
        #1;
      end
      // the pulse spans the count down to zero inclusive
      check(cnt, eta_pkg::ETA_RST_PULSE_CYC + 1);
      check(cs, (m == 4) ? 0 : eta_pkg::ETA_RST_PULSE_CYC + 1);
      if (m < 4) begin
        check(halt_req, m[0]);
        check(start_vector, (m < 2) ? eta_pkg::ETA_HIGH_VECTOR : eta_pkg::ETA_LOW_VECTOR);
      end
    end
    // idle, pulses over, last target mode left halted
    cfg_read(4'h4);
    check(v, 32'h0000_0020);
    // first two rounds are fixed corners: copy-back write hit, narrow encoded read
    for (int i = 0; i < 24; i++) begin
      lf = (i == 0) ? 32'h0028_7081 : (i == 1) ? 32'h00d8_004a : (i == 2) ? 32'hffc4eb50 : nxt(lf);
      md = lf[5:0];
      if (md[5:4] == 2'h3) md[5:4] = 2'h0;
      // retry follows the target's pin whenever a cache is on
      if (lf[6] || lf[7]) md[2] = 1'b1;
      rdd = lf[9:8];
      wrd = lf[11:10];
      cfg_write(4'h3, {26'h0, md});
      cfg_write(4'h1, {30'h0, rdd});
      cfg_write(4'h2, {30'h0, wrd});
      rq.write       = lf[12];
      rq.space_given = lf[13];
      rq.data_space  = lf[14];
      rq.download    = lf[12] & lf[15] & lf[16];
      rq.size        = (lf[19:17] > 3'h4) ? 3'h4 : lf[19:17];
      rq.addr        = nxt(lf);
      rq.wdata       = {lf, nxt(nxt(lf))};
      @(posedge sys_clk);
      instr_cache_on_bit <= lf[6];
      data_cache_on_bit  <= lf[7];
      icache_hit         <= lf[20] & lf[6];
      dcache_hit         <= lf[21] & lf[7] & ~(lf[20] & lf[6]);
      icache_encoded     <= lf[22];
      insn_valid         <= lf[23];
      slow               <= lf[24];
      phys_data          <= {lf, ~lf};
      icache_raw         <= {~lf, lf};
      icache_dec         <= {lf ^ 32'h5a5a_5a5a, lf};
      dcache_data        <= {lf, lf ^ 32'h0f0f_0f0f};
      access();
      check(n >= 25 * (rq.write ? wrd : rdd) && n < 400, 1'b1);
      check(ad, rq.addr);
      check(pl.retry_hs, md[2] & (lf[6] | lf[7]));
      check(pl.size, (md[1] && rq.size == eta_pkg::ETA_SIZE_8B) ? eta_pkg::ETA_SIZE_4B : rq.size);
      if (!rq.write) begin
        check(rdata, exp_rd());
        check(pl.par, md[0] ? 8'hff : 8'h00);
      end else begin
        if (!md[0] || !md[1]) check(pl.par, md[0] ? odd_par(rq.wdata) : 8'h00);
        if (rq.download || (rq.space_given && rq.data_space))
          check({pl.to_phys, pl.to_dcache, pl.mark_dirty, pl.invalidate}, exp_wr());
        else
          check({pl.to_phys, pl.to_icache, pl.to_dcache, pl.mark_dirty, pl.invalidate},
                {1'b1, icache_hit, dcache_hit, 2'b00});
      end
    end
    complete_run();
  end
endmodule

bind eta_target_access eta_target_access_assertions u_chk (
  .sys_clk, .rst, .req_ready, .done, .scan_ack, .scan_go, .plan, .addr_out, .core_rst, .scan_rst
);
